// file: rtl/p4hm_pkg.sv
// Package with register address, field layout and mode codes of the pin mode block
package p4hm_pkg;
    localparam logic [7:0] P4HM_REG_ADDR   = 8'hee; // Register offset in page
    localparam logic       P4HM_REG_PAGE   = 1'b1;  // Second register page
    localparam logic [7:0] P4HM_RESET_VAL  = 8'h00; // All pins input
    localparam int         P4HM_FIELD_W    = 2;     // Bits per pin field
    localparam int         P4HM_PINS       = 4;     // Upper four pins
    localparam logic [1:0] P4HM_MODE_IN    = 2'h0;  // Plain input
    localparam logic [1:0] P4HM_MODE_UART  = 2'h1;  // Serial alternative
    localparam logic [1:0] P4HM_MODE_LCD   = 2'h2;  // Segment drive
    localparam logic [1:0] P4HM_MODE_OUT   = 2'h3;  // Plain output
endpackage

// file: rtl/p4hm_pin_cell.sv
// One pin cell: decodes a 2-bit mode field into pin drive and enable
`timescale 1ns/1ps
`default_nettype none
module p4hm_pin_cell
    import p4hm_pkg::*;
(
    input  wire logic       i_clk,     // System clock
    input  wire logic       i_rst,     // Async reset, active high
    input  wire logic [1:0] i_mode,    // Mode field
    input  wire logic       i_gpio,    // Port data latch bit
    input  wire logic       i_uart,    // Serial function signal
    input  wire logic       i_lcd,     // Segment drive signal
    input  wire logic       i_pin,     // Pin level from pad
    output logic            o_pin,     // Pad output level
    output logic            o_pin_oe,  // Pad output enable
    output logic            o_pin_in   // Synchronised pin level
);
    logic pin_d, pin_q, oe_d, oe_q;    // Registered pad drive
    logic sync1_q, sync2_q;            // Input synchroniser

    // Select pad drive from the mode field
    always_comb
    begin
        pin_d = 1'b0;
        oe_d  = 1'b1;
        unique case (i_mode)
            P4HM_MODE_IN:   oe_d  = 1'b0;
            P4HM_MODE_UART: pin_d = i_uart;
            P4HM_MODE_LCD:  pin_d = i_lcd;
            P4HM_MODE_OUT:  pin_d = i_gpio;
        endcase
    end

    // Register drive and synchronise pad input
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            pin_q   <= 1'b0;
            oe_q    <= 1'b0;
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
        end
        else
        begin
            pin_q   <= pin_d;
            oe_q    <= oe_d;
            sync1_q <= i_pin;
            sync2_q <= sync1_q;
        end
    end

    assign o_pin    = pin_q;
    assign o_pin_oe = oe_q;
    assign o_pin_in = sync2_q;

    // Input mode never drives the pad one cycle later
    a_input_no_drive: assert property (
        @(posedge i_clk) disable iff (i_rst)
        i_mode == P4HM_MODE_IN |=> !o_pin_oe)
        else $error("pad driven in input mode");
endmodule
`default_nettype wire

// file: rtl/p4hm_top.sv
// Upper port pin mode register and pin multiplexer
// Behaviour
// - Register sits at EE, second page.
// - Reached by direct register addressing only.
// - Field 5:4 = 01 drives uart A transmit.
// - Field 5:4 = 10 drives segment line c.
// - Field 3:2 = 01 outputs uart B receive.
// - Field 3:2 = 10 drives segment line b.
`timescale 1ns/1ps
`default_nettype none
module p4hm_top
    import p4hm_pkg::*;
(
    input  wire logic       I_CLK,                   // 100 MHz clock
    input  wire logic       I_RST,                   // Async reset, high
    input  wire logic [7:0] I_REG_ADDR,              // Direct register address
    input  wire logic       I_REG_PAGE,              // Register page select
    input  wire logic       I_REG_WR,                // Write strobe
    input  wire logic       I_REG_RD,                // Read strobe
    input  wire logic [7:0] I_REG_WDATA,             // Write data
    output logic [7:0]      O_REG_RDATA,             // Read data
    output logic            O_REG_HIT,               // Address selects block
    input  wire logic [3:0] I_GPIO_OUT,              // Port data latch 7:4
    input  wire logic       I_UART_A_RECEIVE_DATA,   // Uart A rx echo
    input  wire logic       I_UART_A_TRANSMIT_DATA,  // Uart A tx
    input  wire logic       I_UART_B_RECEIVE_DATA,   // Uart B rx echo
    input  wire logic       I_UART_B_TRANSMIT_DATA,  // Uart B tx
    input  wire logic [3:0] I_LCD_SEG,               // Segment lines d..a
    input  wire logic [3:0] I_PIN,                   // Pad levels 7:4
    output logic [3:0]      O_PIN,                   // Pad drive 7:4
    output logic [3:0]      O_PIN_OE,                // Pad enables 7:4
    output logic [3:0]      O_PIN_IN,                // Synced pad levels
    output logic [7:0]      O_MODE                   // Current mode register
);
    logic [7:0] port4_pin_mode_high_q;  // Mode register
    logic [7:0] port4_pin_mode_high_d;  // Next mode register
    logic [7:0] rdata_d, rdata_q;       // Read data register
    logic       hit;                    // Direct address decode
    logic [3:0] uart_sig;               // Serial signal per pin

    // Only a direct register access to EE on page one selects us
    assign hit = (I_REG_ADDR == P4HM_REG_ADDR)
              && (I_REG_PAGE == P4HM_REG_PAGE);
    assign O_REG_HIT = hit;

    // Next register and read data
    always_comb
    begin
        port4_pin_mode_high_d = port4_pin_mode_high_q;
        rdata_d               = 8'h00;
        if (hit && I_REG_WR)
        begin
            port4_pin_mode_high_d = I_REG_WDATA;
        end
        if (hit && I_REG_RD)
        begin
            rdata_d = port4_pin_mode_high_q;
        end
    end

    // Register state, cleared to all-input on reset
    always_ff @(posedge I_CLK or posedge I_RST)
    begin
        if (I_RST)
        begin
            port4_pin_mode_high_q <= P4HM_RESET_VAL;
            rdata_q               <= 8'h00;
        end
        else
        begin
            port4_pin_mode_high_q <= port4_pin_mode_high_d;
            rdata_q               <= rdata_d;
        end
    end

    assign O_REG_RDATA = rdata_q;
    assign O_MODE      = port4_pin_mode_high_q;

    // Serial function per pin: 7 rx A, 6 tx A, 5 rx B, 4 tx B
    assign uart_sig = {I_UART_A_RECEIVE_DATA,
                       I_UART_A_TRANSMIT_DATA,
                       I_UART_B_RECEIVE_DATA,
                       I_UART_B_TRANSMIT_DATA};

    // One cell per pin; field 2k+1:2k controls pin k+4
    genvar k;
    generate
        for (k = 0; k < P4HM_PINS; k++)
        begin : g_pin
            p4hm_pin_cell u_cell (
                .i_clk    (I_CLK),
                .i_rst    (I_RST),
                .i_mode   (port4_pin_mode_high_q[2*k +: 2]),
                .i_gpio   (I_GPIO_OUT[k]),
                .i_uart   (uart_sig[k]),
                .i_lcd    (I_LCD_SEG[k]),
                .i_pin    (I_PIN[k]),
                .o_pin    (O_PIN[k]),
                .o_pin_oe (O_PIN_OE[k]),
                .o_pin_in (O_PIN_IN[k])
            );
        end
    endgenerate

    // A hit write strobe whose data carries value v in field lo+1:lo
    sequence s_mode_write(logic [1:0] v, int lo);
        hit && I_REG_WR && I_REG_WDATA[lo +: 2] == v;
    endsequence

    // The stored field lo+1:lo holds value v
    sequence s_field_held(logic [1:0] v, int lo);
        O_MODE[lo +: 2] == v;
    endsequence

    // A hit read strobe
    sequence s_mode_read;
        hit && I_REG_RD;
    endsequence

    // A hit write lands whole in the register at the next edge
    property p_write_stores;
        @(posedge I_CLK) disable iff (I_RST)
        hit && I_REG_WR |=> O_MODE == $past(I_REG_WDATA);
    endproperty
    a_write_stores: assert property (p_write_stores)
        else $error("write to mode register lost");

    // Anything but a direct hit leaves the register alone
    property p_miss_keeps;
        @(posedge I_CLK) disable iff (I_RST)
        !hit |=> $stable(O_MODE);
    endproperty
    a_miss_keeps: assert property (p_miss_keeps)
        else $error("mode changed without direct hit");

    // A hit read returns the value held before any same-cycle write
    property p_read_returns;
        @(posedge I_CLK) disable iff (I_RST)
        s_mode_read |=> O_REG_RDATA == $past(O_MODE);
    endproperty
    a_read_returns: assert property (p_read_returns)
        else $error("read data differs from mode register");

    // Without a hit read the read data bus rests at zero
    property p_idle_rdata;
        @(posedge I_CLK) disable iff (I_RST)
        !(hit && I_REG_RD) |=> O_REG_RDATA == 8'h00;
    endproperty
    a_idle_rdata: assert property (p_idle_rdata)
        else $error("read data without a direct hit read");

    // Reset leaves every pin an undriven input
    property p_reset_clear;
        @(posedge I_CLK)
        I_RST |-> O_MODE == P4HM_RESET_VAL && O_PIN_OE == 4'h0
                  && O_PIN == 4'h0;
    endproperty
    a_reset_clear: assert property (p_reset_clear)
        else $error("pins not cleared during reset");

    // Writing the serial code to pin six hands it uart A transmit
    property p_tx_a_route;
        @(posedge I_CLK) disable iff (I_RST)
        s_mode_write(P4HM_MODE_UART, 4) ##1 s_field_held(P4HM_MODE_UART, 4)
        |=> O_PIN_OE[2] && O_PIN[2] == $past(I_UART_A_TRANSMIT_DATA);
    endproperty
    a_tx_a_route: assert property (p_tx_a_route)
        else $error("pin six not carrying uart A tx");

    // Segment code on pin six drives segment line c
    property p_lcd_six;
        @(posedge I_CLK) disable iff (I_RST)
        s_field_held(P4HM_MODE_LCD, 4) |=>
            O_PIN_OE[2] && O_PIN[2] == $past(I_LCD_SEG[2]);
    endproperty
    a_lcd_six: assert property (p_lcd_six)
        else $error("pin six not carrying segment c");

    // Serial code on pin five drives out uart B receive
    property p_rx_b_route;
        @(posedge I_CLK) disable iff (I_RST)
        s_field_held(P4HM_MODE_UART, 2) |=>
            O_PIN_OE[1] && O_PIN[1] == $past(I_UART_B_RECEIVE_DATA);
    endproperty
    a_rx_b_route: assert property (p_rx_b_route)
        else $error("pin five not carrying uart B rx");

    // Segment code on pin five drives segment line b
    property p_lcd_five;
        @(posedge I_CLK) disable iff (I_RST)
        s_field_held(P4HM_MODE_LCD, 2) |=>
            O_PIN_OE[1] && O_PIN[1] == $past(I_LCD_SEG[1]);
    endproperty
    a_lcd_five: assert property (p_lcd_five)
        else $error("pin five not carrying segment b");

    // Output code on pin seven drives the port data latch bit
    property p_out_mode;
        @(posedge I_CLK) disable iff (I_RST)
        s_field_held(P4HM_MODE_OUT, 6) |=>
            O_PIN_OE[3] && O_PIN[3] == $past(I_GPIO_OUT[3]);
    endproperty
    a_out_mode: assert property (p_out_mode)
        else $error("pin seven output mode wrong");

    // Input code on pin four keeps its pad undriven
    property p_in_top;
        @(posedge I_CLK) disable iff (I_RST)
        s_field_held(P4HM_MODE_IN, 0) |=> !O_PIN_OE[0];
    endproperty
    a_in_top: assert property (p_in_top)
        else $error("pin four driven in input mode");

    // Serial code on pin seven drives out uart A receive
    property p_rx_a_route;
        @(posedge I_CLK) disable iff (I_RST)
        s_field_held(P4HM_MODE_UART, 6) |=>
            O_PIN_OE[3] && O_PIN[3] == $past(I_UART_A_RECEIVE_DATA);
    endproperty
    a_rx_a_route: assert property (p_rx_a_route)
        else $error("pin seven not carrying uart A rx");

    // Serial code on pin four carries uart B transmit
    property p_tx_b_route;
        @(posedge I_CLK) disable iff (I_RST)
        s_field_held(P4HM_MODE_UART, 0) |=>
            O_PIN_OE[0] && O_PIN[0] == $past(I_UART_B_TRANSMIT_DATA);
    endproperty
    a_tx_b_route: assert property (p_tx_b_route)
        else $error("pin four not carrying uart B tx");

    // Segment code on pin seven drives segment line d
    property p_lcd_seven;
        @(posedge I_CLK) disable iff (I_RST)
        s_field_held(P4HM_MODE_LCD, 6) |=>
            O_PIN_OE[3] && O_PIN[3] == $past(I_LCD_SEG[3]);
    endproperty
    a_lcd_seven: assert property (p_lcd_seven)
        else $error("pin seven not carrying segment d");

    // Segment code on pin four drives segment line a
    property p_lcd_four;
        @(posedge I_CLK) disable iff (I_RST)
        s_field_held(P4HM_MODE_LCD, 0) |=>
            O_PIN_OE[0] && O_PIN[0] == $past(I_LCD_SEG[0]);
    endproperty
    a_lcd_four: assert property (p_lcd_four)
        else $error("pin four not carrying segment a");

    // Output code on pin four drives the port data latch bit
    property p_out_four;
        @(posedge I_CLK) disable iff (I_RST)
        s_field_held(P4HM_MODE_OUT, 0) |=>
            O_PIN_OE[0] && O_PIN[0] == $past(I_GPIO_OUT[0]);
    endproperty
    a_out_four: assert property (p_out_four)
        else $error("pin four output mode wrong");
endmodule
`default_nettype wire

// file: tb/p4hm_top_tb_top.sv
// Self-checking testbench for the upper port pin mode block
`timescale 1ns/1ps
`default_nettype none
module p4hm_top_tb_top;
    import p4hm_pkg::*;
    logic        clk, rst, wr, rd, page;      // Clock, reset, bus controls
    logic        ua_r, ua_t, ub_r, ub_t;      // Serial function signals
    logic [7:0]  addr, wdata, rdata, mode, m; // Bus values, current pattern
    logic [3:0]  gpio, seg, pin_i, pin_o;     // Pin side values
    logic [3:0]  pin_oe, pin_s, e_oe, e_pin;  // Enables, synced, expected
    logic        hit;                         // Address decode
    logic [31:0] seed = 32'hdcef1b0b;         // Random state
    int          fail_count, num_checks, cyc; // Counters
    p4hm_top p4hm_top_i (.I_CLK(clk), .I_RST(rst), .I_REG_ADDR(addr),
        .I_REG_PAGE(page), .I_REG_WR(wr), .I_REG_RD(rd),
        .I_REG_WDATA(wdata), .O_REG_RDATA(rdata), .O_REG_HIT(hit),
        .I_GPIO_OUT(gpio), .I_UART_A_RECEIVE_DATA(ua_r),
        .I_UART_A_TRANSMIT_DATA(ua_t), .I_UART_B_RECEIVE_DATA(ub_r),
        .I_UART_B_TRANSMIT_DATA(ub_t), .I_LCD_SEG(seg), .I_PIN(pin_i),
        .O_PIN(pin_o), .O_PIN_OE(pin_oe), .O_PIN_IN(pin_s), .O_MODE(mode));
    // Clock of 10 ns period
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Xorshift source of stimulus
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // Expected {enable, level} of pin k+4 for a mode field
    function automatic logic [1:0] exp_pin(input logic [1:0] f, input int k);
        case (f)
            P4HM_MODE_UART: return {1'b1, k == 3 ? ua_r : k == 2 ? ua_t :
                                    k == 1 ? ub_r : ub_t};
            P4HM_MODE_LCD:  return {1'b1, seg[k]};
            P4HM_MODE_OUT:  return {1'b1, gpio[k]};
            default:        return 2'b00;
        endcase
    endfunction
    // Compare and count
    task automatic chk(string n, logic [7:0] e, logic [7:0] s);
        num_checks++;
        if (s !== e)
        begin
            $display("[FAIL] %s expected %h seen %h", n, e, s);
            fail_count++;
        end
    endtask
    // One bus cycle after an idle edge: write when w is high, else read
    task automatic acc(input logic [7:0] a, input logic p, input logic w,
                       input logic [7:0] d);
        @(posedge clk);
        #1 {addr, page, wdata, wr, rd} = {a, p, d, w, !w};
        @(posedge clk);
        #1 {wr, rd} = 2'b00;
    endtask
    // Closing report
    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // Timeout guard
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            fail_count++;
            test_done();
        end
    end
    // Main sequence
    initial
    begin
        {rst, wr, rd, page, ua_r, ua_t, ub_r, ub_t} = 8'h80;
        {addr, wdata, gpio, seg, pin_i} = '0;
        repeat (4) @(posedge clk);
        #1 rst = 1'b0;
        chk("reset mode", P4HM_RESET_VAL, mode);
        chk("reset enable", 8'h00, {4'h0, pin_oe});
        acc(P4HM_REG_ADDR, P4HM_REG_PAGE, 0, 8'h00);
        chk("reset read", P4HM_RESET_VAL, rdata);
        for (int i = 0; i < 40; i++)
        begin
            m = (i < 4) ? {4{i[1:0]}} : 8'(xs());
            {ua_r, ua_t, ub_r, ub_t, gpio, seg, pin_i} = 16'(xs());
            acc(P4HM_REG_ADDR, P4HM_REG_PAGE, 1, m);
            acc(P4HM_REG_ADDR, P4HM_REG_PAGE, 0, 8'h00);
            chk("read back", m, rdata);
            chk("hit", 8'h01, {7'h0, hit});
            for (int k = 0; k < 4; k++)
                {e_oe[k], e_pin[k]} = exp_pin(m[2*k +: 2], k);
            chk("pin enable", 8'(e_oe), 8'(pin_oe));
            chk("pin level", 8'(e_pin), 8'(pin_o));
            chk("pin sync", {4'h0, pin_i}, {4'h0, pin_s});
        end
        acc(P4HM_REG_ADDR, !P4HM_REG_PAGE, 1, ~m);
        acc(P4HM_REG_ADDR + 8'h01, P4HM_REG_PAGE, 1, ~m);
        chk("foreign write", m, mode);
        chk("foreign decode", 8'h00, {7'h0, hit});
        acc(P4HM_REG_ADDR, !P4HM_REG_PAGE, 0, 8'h00);
        chk("foreign read", 8'h00, rdata);
        rst = 1'b1;
        #1 chk("mid reset", P4HM_RESET_VAL, mode);
        chk("mid reset enable", 8'h00, 8'(pin_oe));
        @(posedge clk);
        #1 rst = 1'b0;
        acc(P4HM_REG_ADDR, P4HM_REG_PAGE, 1, 8'hff);
        chk("after reset", 8'hff, mode);
        test_done();
    end
endmodule
`default_nettype wire
